// >>> logic/irq_route_controller.sv
// Added by the designer: the register addresses and the APB slave port.
module irq_route_controller (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Interrupt
   output logic IRQ_OUT,
   // Link to the device
   irq_route_if.controller LINK
);
   typedef enum logic [1:0] {H_IDLE, H_INDEX, H_ACCESS, H_WAIT} host_e;
   host_e state_q;
   logic scan_q;
   logic [2:0] sel_q;
   logic [2:0] sel_prev_q;
   logic scan_prev_q;
   logic [15:0] level_q;
   logic [15:0] level_d;
   logic [16:0] status_q;
   logic [16:0] mask_q;
   logic [16:0] events;
   logic [7:0] acc_data_q;
   logic [2:0] acc_addr_q;
   logic [2:0] acc_index_q;
   logic acc_read_q;
   logic [7:0] result_q;
   logic done;
   logic io_wr_q;
   logic io_rd_q;
   logic [2:0] io_addr_q;
   logic [7:0] io_wdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic irq_q;
   logic commit;
   logic wr_commit;
   logic mapped;

   // Access phase ends one cycle after it starts
   assign commit = PSEL && PENABLE && pready_q;
   assign wr_commit = commit && PWRITE && !pslverr_q;
   assign mapped = PADDR == irq_route_pkg::OFF_CTRL || PADDR == irq_route_pkg::OFF_ACCESS
      || PADDR == irq_route_pkg::OFF_RESULT || PADDR == irq_route_pkg::OFF_LEVELS
      || PADDR == irq_route_pkg::OFF_INT_STATUS || PADDR == irq_route_pkg::OFF_INT_MASK;

   // APB answer
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= PSEL && PENABLE && !pready_q;
         pslverr_q <= PSEL && PENABLE && !pready_q && !mapped;
         prdata_q <= 32'h0000_0000;
         if (PSEL && PENABLE && !pready_q && !PWRITE)
         begin
            unique case (PADDR)
               irq_route_pkg::OFF_CTRL: prdata_q <= {31'h0, scan_q};
               irq_route_pkg::OFF_ACCESS:
                  prdata_q <= {15'h0, acc_read_q, 1'b0, acc_index_q, 1'b0, acc_addr_q, acc_data_q};
               irq_route_pkg::OFF_RESULT:
                  prdata_q <= {23'h0, state_q != H_IDLE, result_q};
               irq_route_pkg::OFF_LEVELS: prdata_q <= {16'h0, level_q};
               irq_route_pkg::OFF_INT_STATUS: prdata_q <= {15'h0, status_q};
               irq_route_pkg::OFF_INT_MASK: prdata_q <= {15'h0, mask_q};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control and mask registers
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         scan_q <= 1'b0;
         mask_q <= '0;
      end
      else if (wr_commit)
      begin
         if (PADDR == irq_route_pkg::OFF_CTRL)
            scan_q <= PWDATA[irq_route_pkg::CTRL_SCAN_BIT];
         if (PADDR == irq_route_pkg::OFF_INT_MASK)
            mask_q <= PWDATA[irq_route_pkg::INT_W-1:0];
      end
   end

   // Select line scan, one select code (two slots, one per bank) per cycle
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sel_q <= 3'h0;
         sel_prev_q <= 3'h0;
         scan_prev_q <= 1'b0;
      end
      else
      begin
         if (scan_q)
            sel_q <= sel_q + 3'h1;
         sel_prev_q <= sel_q;
         scan_prev_q <= scan_q;
      end
   end

   // Device output lags the select by one cycle
   always_comb
   begin
      level_d = level_q;
      if (scan_prev_q)
      begin
         level_d[{1'b0, sel_prev_q}] = LINK.mux_irq_out_a;
         level_d[{1'b1, sel_prev_q}] = LINK.mux_irq_out_b;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         level_q <= 16'h0000;
      else
         level_q <= level_d;
   end

   assign events = {done, level_d & ~level_q};

   // Sticky status, set beats write-one clear
   always_ff @(posedge CLK)
   begin
      if (RST)
         status_q <= '0;
      else if (wr_commit && PADDR == irq_route_pkg::OFF_INT_STATUS)
         status_q <= (status_q & ~PWDATA[irq_route_pkg::INT_W-1:0]) | events;
      else
         status_q <= status_q | events;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         irq_q <= 1'b0;
      else
         irq_q <= |(status_q & mask_q);
   end

   // Indexed access sequencer
   assign done = (state_q == H_ACCESS && !acc_read_q) || (state_q == H_WAIT && LINK.io_rvalid);

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_q <= H_IDLE;
         acc_data_q <= 8'h00;
         acc_addr_q <= 3'h0;
         acc_index_q <= 3'h0;
         acc_read_q <= 1'b0;
         result_q <= 8'h00;
         io_wr_q <= 1'b0;
         io_rd_q <= 1'b0;
         io_addr_q <= 3'h0;
         io_wdata_q <= 8'h00;
      end
      else
      begin
         io_wr_q <= 1'b0;
         io_rd_q <= 1'b0;
         unique case (state_q)
            H_IDLE:
               if (wr_commit && PADDR == irq_route_pkg::OFF_ACCESS)
               begin
                  acc_data_q <= PWDATA[irq_route_pkg::ACC_DATA_LSB +: 8];
                  acc_addr_q <= PWDATA[irq_route_pkg::ACC_ADDR_LSB +: 3];
                  acc_index_q <= PWDATA[irq_route_pkg::ACC_INDEX_LSB +: 3];
                  acc_read_q <= PWDATA[irq_route_pkg::ACC_READ_BIT];
                  io_wr_q <= 1'b1;
                  io_addr_q <= irq_route_pkg::INDEX_ADDR;
                  io_wdata_q <= {5'h00, PWDATA[irq_route_pkg::ACC_INDEX_LSB +: 3]};
                  state_q <= H_INDEX;
               end
            H_INDEX:
            begin
               io_wr_q <= !acc_read_q;
               io_rd_q <= acc_read_q;
               io_addr_q <= acc_addr_q;
               io_wdata_q <= acc_data_q;
               state_q <= H_ACCESS;
            end
            H_ACCESS:
               state_q <= acc_read_q ? H_WAIT : H_IDLE;
            H_WAIT:
               if (LINK.io_rvalid)
               begin
                  result_q <= LINK.io_rdata;
                  state_q <= H_IDLE;
               end
         endcase
      end
   end

   assign LINK.mux_select_lines = sel_q;
   assign LINK.io_wr = io_wr_q;
   assign LINK.io_rd = io_rd_q;
   assign LINK.io_addr = io_addr_q;
   assign LINK.io_wdata = io_wdata_q;
   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign IRQ_OUT = irq_q;
endmodule

// >>> logic/irq_route_pkg.sv
package irq_route_pkg;
   // Indexed register window
   localparam logic [2:0] INDEX_ADDR = 3'h5;
   localparam logic [2:0] WINDOW_ADDR = 3'h7;
   localparam logic [2:0] IDX_PAR_ROUTE = 3'h4;
   localparam logic [2:0] IDX_REVISION = 3'h6;
   localparam logic [2:0] INDEX_RESET = 3'h0;
   localparam logic [3:0] PAR_ROUTE_RESET = 4'h0;
   localparam int ROUTE_LSB = 0;
   localparam int ROUTE_W = 4;

   // Routing codes
   localparam logic [3:0] ROUTE_OFF = 4'h0;
   localparam logic [3:0] ROUTE_STANDALONE = 4'hf;

   // Mux input slots: bank a is 0..7, bank b is 8..15
   localparam int SLOTS = 16;
   localparam int BANK = 8;

   // Controller APB map
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ACCESS = 8'h04;
   localparam logic [7:0] OFF_RESULT = 8'h08;
   localparam logic [7:0] OFF_LEVELS = 8'h0c;
   localparam logic [7:0] OFF_INT_STATUS = 8'h10;
   localparam logic [7:0] OFF_INT_MASK = 8'h14;
   localparam int CTRL_SCAN_BIT = 0;
   localparam int ACC_DATA_LSB = 0;
   localparam int ACC_ADDR_LSB = 8;
   localparam int ACC_INDEX_LSB = 12;
   localparam int ACC_READ_BIT = 16;
   localparam int RES_BUSY_BIT = 8;
   localparam int INT_DONE_BIT = 16;
   localparam int INT_W = 17;

   // Slot replaced by a routing code; valid flag in bit 4
   function automatic logic [4:0] route_slot(input logic [3:0] code);
      unique case (code)
         4'h1: route_slot = 5'h1b;
         4'h2: route_slot = 5'h1c;
         4'h3: route_slot = 5'h1d;
         4'h4: route_slot = 5'h1e;
         4'h5: route_slot = 5'h1f;
         4'h6: route_slot = 5'h12;
         4'h7: route_slot = 5'h13;
         4'h8: route_slot = 5'h14;
         4'h9: route_slot = 5'h17;
         default: route_slot = 5'h00;
      endcase
   endfunction
endpackage

// >>> logic/irq_route_if.sv
interface irq_route_if;
   logic [2:0] mux_select_lines;
   logic mux_irq_out_a;
   logic mux_irq_out_b;
   logic io_wr;
   logic io_rd;
   logic [2:0] io_addr;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic io_rvalid;

   modport device (
      input mux_select_lines,
      input io_wr,
      input io_rd,
      input io_addr,
      input io_wdata,
      output mux_irq_out_a,
      output mux_irq_out_b,
      output io_rdata,
      output io_rvalid
   );

   modport controller (
      output mux_select_lines,
      output io_wr,
      output io_rd,
      output io_addr,
      output io_wdata,
      input mux_irq_out_a,
      input mux_irq_out_b,
      input io_rdata,
      input io_rvalid
   );
endinterface

// >>> logic/level_sync.sv
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// >>> logic/irq_route_device.sv
// Operation
// - Second serial wins shared slot, never ORed
// - Parallel interrupt wins over serial, never ORed
// - Parallel routing at index 4, address 7
// - Routing code picks replaced mux input
// - Software writes only defined routing codes
// - Software writes zero to bits 7-4
// - Parallel routing acts only with output enable set
// - Revision reads ones-complement, read only
// - Revision at index 6, address 7
// - First serial all-ones selects stand-alone mode
// - Controller select lines choose sampled inputs
module irq_route_device #(
   // Arbitrary value
   parameter logic [7:0] SILICON_REVISION = 8'h02
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Link to the system controller
   irq_route_if.device LINK,
   // External mux inputs: slots 0..7 bank a, 8..15 bank b
   input wire logic [15:0] IRQ_LINES,
   // Internal port interrupts and routing fields
   input wire logic SERIAL0_IRQ,
   input wire logic SERIAL1_IRQ,
   input wire logic PARALLEL_IRQ,
   input wire logic [3:0] FIRST_SERIAL_IRQ_ROUTE_FIELD,
   input wire logic [3:0] SECOND_SERIAL_IRQ_ROUTE_FIELD,
   input wire logic PARALLEL_IRQ_OUTPUT_ENABLE,
   // Status
   output logic [3:0] PARALLEL_IRQ_ROUTE_FIELD,
   output logic STANDALONE_MODE
);
   logic [2:0] index_q;
   logic [3:0] par_route_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic out_a_q;
   logic out_b_q;
   logic standalone_q;
   logic [15:0] lines_sync;
   logic [15:0] slots;
   logic [4:0] s0_slot;
   logic [4:0] s1_slot;
   logic [4:0] pp_slot;
   logic standalone;
   logic win_wr;
   logic [3:0] sel_a;
   logic [3:0] sel_b;

   level_sync #(.WIDTH(16)) u_lines_sync (
      .clk(CLK),
      .rst(RST),
      .async_in(IRQ_LINES),
      .sync_out(lines_sync)
   );

   assign win_wr = LINK.io_wr && LINK.io_addr == irq_route_pkg::WINDOW_ADDR;
   assign standalone = FIRST_SERIAL_IRQ_ROUTE_FIELD == irq_route_pkg::ROUTE_STANDALONE;
   assign s0_slot = irq_route_pkg::route_slot(FIRST_SERIAL_IRQ_ROUTE_FIELD);
   assign s1_slot = irq_route_pkg::route_slot(SECOND_SERIAL_IRQ_ROUTE_FIELD);
   assign pp_slot = irq_route_pkg::route_slot(par_route_q);

   // Index select register
   always_ff @(posedge CLK)
   begin
      if (RST)
         index_q <= irq_route_pkg::INDEX_RESET;
      else if (LINK.io_wr && LINK.io_addr == irq_route_pkg::INDEX_ADDR)
         index_q <= LINK.io_wdata[2:0];
   end

   // Parallel routing register; revision writes fall through
   always_ff @(posedge CLK)
   begin
      if (RST)
         par_route_q <= irq_route_pkg::PAR_ROUTE_RESET;
      else if (win_wr && index_q == irq_route_pkg::IDX_PAR_ROUTE)
         par_route_q <= LINK.io_wdata[irq_route_pkg::ROUTE_LSB +: irq_route_pkg::ROUTE_W];
   end

   // Read port, one cycle after the strobe
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= LINK.io_rd;
         if (LINK.io_rd)
         begin
            if (LINK.io_addr == irq_route_pkg::INDEX_ADDR)
               rdata_q <= {5'h00, index_q};
            else if (LINK.io_addr != irq_route_pkg::WINDOW_ADDR)
               rdata_q <= 8'h00;
            else if (index_q == irq_route_pkg::IDX_PAR_ROUTE)
               rdata_q <= {4'h0, par_route_q};
            else if (index_q == irq_route_pkg::IDX_REVISION)
               rdata_q <= ~SILICON_REVISION;
            else
               rdata_q <= 8'h00;
         end
      end
   end

   // Slot substitution, later overrides win
   always_comb
   begin
      slots = lines_sync;
      if (s0_slot[4])
         slots[s0_slot[3:0]] = SERIAL0_IRQ;
      if (s1_slot[4])
         slots[s1_slot[3:0]] = SERIAL1_IRQ;
      if (pp_slot[4] && PARALLEL_IRQ_OUTPUT_ENABLE)
         slots[pp_slot[3:0]] = PARALLEL_IRQ;
   end

   assign sel_a = {1'b0, LINK.mux_select_lines};
   assign sel_b = {1'b1, LINK.mux_select_lines};

   // Multiplexed outputs
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
         standalone_q <= 1'b0;
      end
      else
      begin
         standalone_q <= standalone;
         if (standalone)
         begin
            out_a_q <= SERIAL0_IRQ;
            out_b_q <= SERIAL1_IRQ;
         end
         else
         begin
            out_a_q <= slots[sel_a];
            out_b_q <= slots[sel_b];
         end
      end
   end

   assign LINK.mux_irq_out_a = out_a_q;
   assign LINK.mux_irq_out_b = out_b_q;
   assign LINK.io_rdata = rdata_q;
   assign LINK.io_rvalid = rvalid_q;
   assign PARALLEL_IRQ_ROUTE_FIELD = par_route_q;
   assign STANDALONE_MODE = standalone_q;
endmodule

// >>> verif/irq_route_sva.sv
module irq_route_sva #(
   // Arbitrary value
   parameter logic [7:0] SILICON_REVISION = 8'h02
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [2:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] idx_q;
   logic [3:0] route_q;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // Shadow of the index and of the routing register
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         idx_q <= irq_route_pkg::INDEX_RESET;
      end
      else if (io_wr && io_addr == irq_route_pkg::INDEX_ADDR)
      begin
         idx_q <= io_wdata[2:0];
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         route_q <= irq_route_pkg::PAR_ROUTE_RESET;
      end
      else if (io_wr && io_addr == irq_route_pkg::WINDOW_ADDR
               && idx_q == irq_route_pkg::IDX_PAR_ROUTE)
      begin
         route_q <= io_wdata[3:0];
      end
   end

   rd_answer_a: assert property (io_rd |=> io_rvalid)
      else $error("read strobe not answered");
   rvalid_cause_a: assert property (io_rvalid |-> $past(io_rd))
      else $error("read valid without read strobe");
   rd_single_a: assert property (io_rd |=> !io_rd)
      else $error("read strobe longer than one cycle");
   rdata_hold_a: assert property (!io_rvalid |-> $stable(io_rdata))
      else $error("read data changed without a read");
   strobe_excl_a: assert property (!(io_wr && io_rd))
      else $error("read and write strobes together");
   index_first_a: assert property (io_rd |-> $past(io_wr)
      && $past(io_addr) == irq_route_pkg::INDEX_ADDR)
      else $error("window read without index write");
   rev_read_a: assert property (io_rd && io_addr == irq_route_pkg::WINDOW_ADDR
      && idx_q == irq_route_pkg::IDX_REVISION |=> io_rdata == ~SILICON_REVISION)
      else $error("revision read wrong");
   route_read_a: assert property (io_rd && io_addr == irq_route_pkg::WINDOW_ADDR
      && idx_q == irq_route_pkg::IDX_PAR_ROUTE |=> io_rdata == {4'h0, route_q})
      else $error("routing read wrong");
endmodule

// >>> verif/port_irq_routing_select_tb.sv
`define CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("BAD %s expected %h seen %h", what, (exp), (got)); \
      end \
   end

module port_irq_routing_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary value
   localparam logic [7:0] REV = 8'h5a;
   localparam int SLOT [10] = '{0, 11, 12, 13, 14, 15, 2, 3, 4, 7};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq_out;
   logic standalone;
   logic [3:0] par_route;
   logic [15:0] lines = 16'h0000;
   logic ser0 = 1'b0;
   logic ser1 = 1'b0;
   logic par = 1'b0;
   logic par_en = 1'b0;
   logic [3:0] route0 = 4'h0;
   logic [3:0] route1 = 4'h0;
   logic [31:0] rd;
   logic err;
   int errors = 0;
   int n_compared = 0;

   irq_route_if link ();

   irq_route_device #(.SILICON_REVISION(REV)) irq_route_device_inst (
      .CLK(clk), .RST(rst), .LINK(link.device), .IRQ_LINES(lines),
      .SERIAL0_IRQ(ser0), .SERIAL1_IRQ(ser1), .PARALLEL_IRQ(par),
      .FIRST_SERIAL_IRQ_ROUTE_FIELD(route0), .SECOND_SERIAL_IRQ_ROUTE_FIELD(route1),
      .PARALLEL_IRQ_OUTPUT_ENABLE(par_en), .PARALLEL_IRQ_ROUTE_FIELD(par_route),
      .STANDALONE_MODE(standalone));

   irq_route_controller irq_route_controller_inst (
      .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ_OUT(irq_out), .LINK(link.controller));

   irq_route_sva #(.SILICON_REVISION(REV)) irq_route_sva_inst (
      .CLK(clk), .RST(rst), .io_wr(link.io_wr), .io_rd(link.io_rd),
      .io_addr(link.io_addr), .io_wdata(link.io_wdata), .io_rdata(link.io_rdata),
      .io_rvalid(link.io_rvalid));

   always #5 clk = ~clk;

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Ends when PREADY rises; the watchdog ends a wait that hangs
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Window access through the controller, then wait until not busy
   task automatic win(input logic rdn, input logic rev, input logic [7:0] d);
      logic [2:0] idx;
      idx = rev ? irq_route_pkg::IDX_REVISION : irq_route_pkg::IDX_PAR_ROUTE;
      apb(1'b1, irq_route_pkg::OFF_ACCESS,
          {15'h0, rdn, 1'b0, idx, 1'b0, irq_route_pkg::WINDOW_ADDR, d});
      apb(1'b0, irq_route_pkg::OFF_RESULT, 32'h0);
      while (rd[irq_route_pkg::RES_BUSY_BIT] !== 1'b0)
      begin
         apb(1'b0, irq_route_pkg::OFF_RESULT, 32'h0);
      end
   endtask

   // Full scan of eight select codes plus sync latency
   task automatic levels(input logic [15:0] exp);
      repeat (24) @(posedge clk);
      apb(1'b0, irq_route_pkg::OFF_LEVELS, 32'h0);
      `CHK("levels", exp, rd[15:0])
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      end_of_test();
   end

   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      win(1'b1, 1'b0, 8'h00);
      `CHK("route reset", 8'h00, rd[7:0])
      win(1'b1, 1'b1, 8'h00);
      `CHK("revision", ~REV, rd[7:0])
      win(1'b0, 1'b1, 8'h33);
      win(1'b1, 1'b1, 8'h00);
      `CHK("revision kept", ~REV, rd[7:0])
      win(1'b0, 1'b0, 8'h09);
      win(1'b1, 1'b0, 8'h00);
      `CHK("route", 8'h09, rd[7:0])
      `CHK("route port", 4'h9, par_route)
      apb(1'b0, 8'h18, 32'h0);
      `CHK("slverr", 1'b1, err)
      $display("test registers done");
      apb(1'b1, irq_route_pkg::OFF_CTRL, 32'h1);
      par <= 1'b1;
      par_en <= 1'b1;
      for (int c = 0; c < 10; c++)
      begin
         win(1'b0, 1'b0, 8'(c));
         levels((c == 0) ? 16'h0000 : 16'h0001 << SLOT[c]);
      end
      par_en <= 1'b0;
      levels(16'h0000);
      $display("test routing done");
      route0 <= 4'h2;
      route1 <= 4'h2;
      ser0 <= 1'b1;
      levels(16'h0000);
      ser0 <= 1'b0;
      ser1 <= 1'b1;
      levels(16'h1000);
      par <= 1'b0;
      par_en <= 1'b1;
      win(1'b0, 1'b0, 8'h02);
      levels(16'h0000);
      route0 <= 4'h0;
      route1 <= 4'h0;
      lines <= 16'ha55a;
      win(1'b0, 1'b0, 8'h00);
      levels(16'ha55a);
      win(1'b0, 1'b0, 8'h05);
      levels(16'h255a);
      route0 <= 4'hf;
      ser0 <= 1'b1;
      ser1 <= 1'b0;
      levels(16'h00ff);
      `CHK("standalone", 1'b1, standalone)
      $display("test priority done");
      apb(1'b1, irq_route_pkg::OFF_INT_STATUS, 32'h1ffff);
      apb(1'b1, irq_route_pkg::OFF_INT_MASK, 32'h10000);
      win(1'b1, 1'b1, 8'h00);
      repeat (2) @(posedge clk);
      `CHK("irq set", 1'b1, irq_out)
      apb(1'b1, irq_route_pkg::OFF_INT_STATUS, 32'h10000);
      repeat (2) @(posedge clk);
      `CHK("irq cleared", 1'b0, irq_out)
      apb(1'b1, irq_route_pkg::OFF_INT_MASK, 32'h0);
      win(1'b1, 1'b1, 8'h00);
      repeat (2) @(posedge clk);
      `CHK("irq masked", 1'b0, irq_out)
      apb(1'b0, irq_route_pkg::OFF_INT_STATUS, 32'h0);
      `CHK("done status", 1'b1, rd[irq_route_pkg::INT_DONE_BIT])
      $display("test interrupt done");
      end_of_test();
   end
endmodule
